// ### scs_cfg.svh
// Constants of the serial configuration slave port: codes, counts, reset values.
// Included by the package and by the design modules; holds definitions only.
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH

// Upper three bits of every two-wire slave address.
`define SCS_ADDR_UPPER    3'b110
// Command codes chosen for this port.
`define SCS_CMD_WRITE     8'h02
`define SCS_CMD_READ      8'h03
// Bit counter values at the last bit of a byte and of a data word.
`define SCS_BYTE_LAST     4'h7
`define SCS_WORD_LAST     4'hF
// Register address counter start value.
`define SCS_ADDR_RST      8'h00
// Least idle time before a fresh command, and the system clock rate.
`define SCS_IDLE_US       125
`define SCS_CLK_MHZ       200
// Write buffer shape.
`define SCS_FIFO_WIDTH    24
`define SCS_FIFO_DEPTH    8

`endif

// ### scs_pkg.sv
// Types shared by the serial configuration slave port modules.
// Assumes scs_cfg.svh is on the include path.
`include "scs_cfg.svh"

package scs_pkg;

    typedef logic [7:0]  scs_addr_t;
    typedef logic [15:0] scs_data_t;
    typedef logic [6:0]  scs_slave_t;
    typedef logic [3:0]  scs_code_t;

    typedef enum logic [1:0] {SCS_PH_CMD, SCS_PH_ADDR, SCS_PH_DATA} scs_ph_e;
    typedef enum logic [1:0] {SCS_CMD_NONE, SCS_CMD_WR, SCS_CMD_RD} scs_cmd_e;

    // Frame state on the serial clock, cleared whenever chip select is high.
    typedef struct packed {
        scs_ph_e     phase;
        logic        started;
        logic [3:0]  bcnt;
        logic [14:0] shift;
    } scs_frm_s;

    // Link state on the serial clock that lives across frames.
    typedef struct packed {
        scs_cmd_e    cmd;
        scs_addr_t   addr;
        scs_addr_t   wr_addr;
        scs_data_t   wr_data;
        logic        wr_tog;
        scs_addr_t   rd_addr;
        logic        rd_tog;
    } scs_lnk_s;

    // Output shifter on the falling serial clock edge.
    typedef struct packed {
        logic        miso;
        logic        oe;
        scs_data_t   oshift;
    } scs_out_s;

    // System clock state.
    typedef struct packed {
        logic        cs_s1;
        logic        cs_s2;
        logic        wt_s1;
        logic        wt_s2;
        logic        wt_d;
        logic        rt_s1;
        logic        rt_s2;
        logic        rt_d;
        logic        sh_s1;
        logic        sh_s2;
        logic        sl_s1;
        logic        sl_s2;
        logic [14:0] idle_cnt;
        logic        resume;
        scs_slave_t  slave_addr;
        logic        ack;
        logic        dir_read;
        logic        rd_req;
        scs_addr_t   rd_addr;
        logic        rd_pend;
        scs_data_t   rd_word;
        logic        push_v;
        logic [23:0] push_w;
        logic        overrun;
    } scs_sys_s;

endpackage : scs_pkg

// ### scs_fifo.sv
// Flop-based FIFO with a registered output stage and valid/ready on both sides.
// Assumes one clock; en freezes all state while low.
`timescale 1ns/1ps
`include "scs_cfg.svh"

module scs_fifo #(
    parameter int WIDTH = `SCS_FIFO_WIDTH,
    parameter int DEPTH = `SCS_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             en_i,
    // Fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Drain side
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
        logic                        ov;
        logic [WIDTH-1:0]            od;
    } scs_fifo_s;

    scs_fifo_s st_reg;
    scs_fifo_s st_next;
    logic      push;
    logic      pop;

    assign in_ready_o  = (st_reg.cnt != (PW+1)'(DEPTH));
    assign out_valid_o = st_reg.ov;
    assign out_data_o  = st_reg.od;

    always_comb begin
        st_next = st_reg;
        push = in_valid_i && in_ready_o;
        pop  = (st_reg.cnt != '0) && (!st_reg.ov || out_ready_i);
        if (push) begin
            st_next.mem[st_reg.wp] = in_data_i;
            st_next.wp = st_reg.wp + PW'(1);
        end
        if (pop) begin
            st_next.od = st_reg.mem[st_reg.rp];
            st_next.ov = 1'b1;
            st_next.rp = st_reg.rp + PW'(1);
        end else if (out_ready_i) begin
            st_next.ov = 1'b0;
        end
        st_next.cnt = st_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
        end else if (en_i) begin
            st_reg <= st_next;
        end
    end

    fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        st_reg.cnt <= (PW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule : scs_fifo

// ### scs_port.sv
// Serial configuration slave port: SPI slave on the link clock, write words
// buffered toward the register file, read words fetched from it, and the
// two-wire slave address selection with header match.
// Assumes the register file presents rd_data_i one clk_i cycle after
// rd_req_o, and that clk_i turns a read request round in half an SCLK period.
`timescale 1ns/1ps
`include "scs_cfg.svh"

module scs_port #(
    parameter logic [14:0] IDLE_CYC = 15'(`SCS_IDLE_US * `SCS_CLK_MHZ)
) (
    // System clock, reset and enable
    input  wire logic               clk_i,
    input  wire logic               rst_b_i,
    input  wire logic               ce_i,
    // SPI link
    input  wire logic               sclk_i,
    input  wire logic               chip_select_n_i,
    input  wire logic               mosi_i,
    output logic                    miso_o,
    output logic                    miso_oe_o,
    // Address selection
    input  wire logic               addr_mode_factory_i,
    input  wire scs_pkg::scs_code_t factory_code_i,
    input  wire logic               addr_strap_high_i,
    input  wire logic               addr_strap_low_i,
    output scs_pkg::scs_slave_t     slave_addr_o,
    // Two-wire header match
    input  wire logic [7:0]         i2c_hdr_i,
    input  wire logic               i2c_hdr_valid_i,
    output logic                    i2c_ack_o,
    output logic                    i2c_read_o,
    // Register write stream
    output logic                    wr_valid_o,
    output scs_pkg::scs_addr_t      wr_addr_o,
    output scs_pkg::scs_data_t      wr_data_o,
    input  wire logic               wr_ready_i,
    output logic                    wr_overrun_o,
    // Register read fetch
    output logic                    rd_req_o,
    output scs_pkg::scs_addr_t      rd_addr_o,
    input  wire scs_pkg::scs_data_t rd_data_i
);
    import scs_pkg::*;

    scs_frm_s    frm_reg;
    scs_frm_s    frm_next;
    scs_lnk_s    lnk_reg;
    scs_lnk_s    lnk_next;
    scs_out_s    out_reg;
    scs_out_s    out_next;
    scs_sys_s    sys_reg;
    scs_sys_s    sys_next;
    logic        frm_clr_b;
    logic [15:0] shift_in;
    scs_ph_e     ph;
    scs_addr_t   addr_inc;
    logic        fifo_in_ready;
    logic [23:0] fifo_out;

    // The serial clock stops between frames, so the frame state is cleared
    // asynchronously by chip select rather than waiting for an edge.
    assign frm_clr_b = rst_b_i & ~chip_select_n_i;

    assign miso_o       = out_reg.miso;
    assign miso_oe_o    = out_reg.oe;
    assign slave_addr_o = sys_reg.slave_addr;
    assign i2c_ack_o    = sys_reg.ack;
    assign i2c_read_o   = sys_reg.dir_read;
    assign rd_req_o     = sys_reg.rd_req;
    assign rd_addr_o    = sys_reg.rd_addr;
    assign wr_overrun_o = sys_reg.overrun;
    assign wr_addr_o    = fifo_out[23:16];
    assign wr_data_o    = fifo_out[15:0];

    // Rising-edge link logic. The resume level is quasi-static: the system
    // side only changes it while chip select is high, long before the first
    // rising edge of a frame.
    always_comb begin
        frm_next = frm_reg;
        lnk_next = lnk_reg;
        addr_inc = lnk_reg.addr + 8'h01;
        shift_in = {frm_reg.shift, mosi_i};
        ph = frm_reg.phase;
        if (!frm_reg.started && sys_reg.resume && lnk_reg.cmd == SCS_CMD_WR) begin
            ph = SCS_PH_DATA;
        end
        frm_next.started = 1'b1;
        frm_next.shift   = shift_in[14:0];
        frm_next.phase   = ph;
        frm_next.bcnt    = frm_reg.bcnt + 4'h1;
        unique case (ph)
            SCS_PH_CMD: begin
                if (frm_reg.bcnt == `SCS_BYTE_LAST) begin
                    frm_next.bcnt  = 4'h0;
                    frm_next.phase = SCS_PH_ADDR;
                    if (shift_in[7:0] == `SCS_CMD_WRITE) begin
                        lnk_next.cmd = SCS_CMD_WR;
                    end else if (shift_in[7:0] == `SCS_CMD_READ) begin
                        lnk_next.cmd = SCS_CMD_RD;
                    end else begin
                        lnk_next.cmd = SCS_CMD_NONE;
                    end
                end
            end
            SCS_PH_ADDR: begin
                if (frm_reg.bcnt == `SCS_BYTE_LAST) begin
                    frm_next.bcnt  = 4'h0;
                    frm_next.phase = SCS_PH_DATA;
                    lnk_next.addr  = shift_in[7:0];
                    if (lnk_reg.cmd == SCS_CMD_RD) begin
                        lnk_next.rd_addr = shift_in[7:0];
                        lnk_next.rd_tog  = ~lnk_reg.rd_tog;
                    end
                end
            end
            SCS_PH_DATA: begin
                if (frm_reg.bcnt == `SCS_WORD_LAST) begin
                    frm_next.bcnt = 4'h0;
                    if (lnk_reg.cmd == SCS_CMD_WR) begin
                        lnk_next.wr_addr = lnk_reg.addr;
                        lnk_next.wr_data = shift_in;
                        lnk_next.wr_tog  = ~lnk_reg.wr_tog;
                        lnk_next.addr    = addr_inc;
                    end else if (lnk_reg.cmd == SCS_CMD_RD) begin
                        lnk_next.addr    = addr_inc;
                        lnk_next.rd_addr = addr_inc;
                        lnk_next.rd_tog  = ~lnk_reg.rd_tog;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sclk_i or negedge frm_clr_b) begin
        if (!frm_clr_b) begin
            frm_reg <= '{phase: SCS_PH_CMD, started: 1'b0, bcnt: 4'h0, shift: 15'h0};
        end else begin
            frm_reg <= frm_next;
        end
    end

    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lnk_reg <= '{cmd: SCS_CMD_NONE, addr: `SCS_ADDR_RST, wr_addr: 8'h00,
                         wr_data: 16'h0000, wr_tog: 1'b0, rd_addr: 8'h00, rd_tog: 1'b0};
        end else begin
            lnk_reg <= lnk_next;
        end
    end

    // Falling-edge output: MISO is driven only during read data words, so
    // the link stays half-duplex. The fetched word is read here directly; it
    // settled several clk_i cycles after the request, before this edge.
    always_comb begin
        out_next    = out_reg;
        out_next.oe = (frm_reg.phase == SCS_PH_DATA) && (lnk_reg.cmd == SCS_CMD_RD);
        if (out_next.oe && frm_reg.bcnt == 4'h0) begin
            out_next.miso   = sys_reg.rd_word[15];
            out_next.oshift = {sys_reg.rd_word[14:0], 1'b0};
        end else begin
            out_next.miso   = out_reg.oshift[15];
            out_next.oshift = {out_reg.oshift[14:0], 1'b0};
        end
    end

    always_ff @(negedge sclk_i or negedge frm_clr_b) begin
        if (!frm_clr_b) begin
            out_reg <= '{miso: 1'b0, oe: 1'b0, oshift: 16'h0000};
        end else begin
            out_reg <= out_next;
        end
    end

    // System clock side.
    always_comb begin
        sys_next       = sys_reg;
        sys_next.cs_s1 = chip_select_n_i;
        sys_next.cs_s2 = sys_reg.cs_s1;
        sys_next.wt_s1 = lnk_reg.wr_tog;
        sys_next.wt_s2 = sys_reg.wt_s1;
        sys_next.wt_d  = sys_reg.wt_s2;
        sys_next.rt_s1 = lnk_reg.rd_tog;
        sys_next.rt_s2 = sys_reg.rt_s1;
        sys_next.rt_d  = sys_reg.rt_s2;
        sys_next.sh_s1 = addr_strap_high_i;
        sys_next.sh_s2 = sys_reg.sh_s1;
        sys_next.sl_s1 = addr_strap_low_i;
        sys_next.sl_s2 = sys_reg.sl_s1;
        // Idle time since chip select rose; resume is frozen while selected.
        if (sys_reg.cs_s2) begin
            if (sys_reg.idle_cnt != IDLE_CYC) begin
                sys_next.idle_cnt = sys_reg.idle_cnt + 15'h0001;
            end
            sys_next.resume = (sys_next.idle_cnt != IDLE_CYC);
        end else begin
            sys_next.idle_cnt = 15'h0000;
        end
        if (addr_mode_factory_i) begin
            sys_next.slave_addr = {`SCS_ADDR_UPPER, factory_code_i};
        end else begin
            sys_next.slave_addr = {`SCS_ADDR_UPPER, sys_reg.sh_s2, 1'b0,
                                   sys_reg.sl_s2, 1'b0};
        end
        if (i2c_hdr_valid_i) begin
            sys_next.ack      = (i2c_hdr_i[7:1] == sys_reg.slave_addr);
            sys_next.dir_read = i2c_hdr_i[0];
        end
        sys_next.rd_req = (sys_reg.rt_s2 != sys_reg.rt_d);
        if (sys_next.rd_req) begin
            sys_next.rd_addr = lnk_reg.rd_addr;
        end
        sys_next.rd_pend = sys_reg.rd_req;
        if (sys_reg.rd_pend) begin
            sys_next.rd_word = rd_data_i;
        end
        // The link cannot be stalled, so a word that finds the buffer still
        // refusing the previous one is dropped and flagged.
        if (sys_reg.push_v && fifo_in_ready) begin
            sys_next.push_v = 1'b0;
        end
        if (sys_reg.wt_s2 != sys_reg.wt_d) begin
            if (sys_next.push_v) begin
                sys_next.overrun = 1'b1;
            end else begin
                sys_next.push_v = 1'b1;
                sys_next.push_w = {lnk_reg.wr_addr, lnk_reg.wr_data};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sys_reg          <= '0;
            sys_reg.cs_s1    <= 1'b1;
            sys_reg.cs_s2    <= 1'b1;
            sys_reg.idle_cnt <= IDLE_CYC;
        end else if (ce_i) begin
            sys_reg <= sys_next;
        end
    end

    scs_fifo #(
        .WIDTH (`SCS_FIFO_WIDTH),
        .DEPTH (`SCS_FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .en_i        (ce_i),
        .in_valid_i  (sys_reg.push_v),
        .in_data_i   (sys_reg.push_w),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (wr_valid_o),
        .out_data_o  (fifo_out),
        .out_ready_i (wr_ready_i)
    );

    factory_addr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ce_i && addr_mode_factory_i |=> slave_addr_o == {3'b110, $past(factory_code_i)})
        else $error("factory address wrong");
    strap_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ce_i && $past(ce_i) && addr_mode_factory_i && $past(addr_mode_factory_i)
        && $stable(factory_code_i) |=> $stable(slave_addr_o))
        else $error("straps changed factory address");
    pin_addr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ce_i && !addr_mode_factory_i |=> slave_addr_o ==
        {3'b110, $past(sys_reg.sh_s2), 1'b0, $past(sys_reg.sl_s2), 1'b0})
        else $error("pin address wrong");
    hdr_ack_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ce_i && i2c_hdr_valid_i |=> i2c_ack_o == ($past(i2c_hdr_i[7:1]) == $past(slave_addr_o)))
        else $error("acknowledge does not follow address match");
    hdr_dir_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ce_i && i2c_hdr_valid_i |=> i2c_read_o == $past(i2c_hdr_i[0]))
        else $error("direction bit not taken");
    resume_rise_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ce_i && $rose(sys_reg.cs_s2) |=> sys_reg.resume)
        else $error("early frame not marked as continuation");
    idle_expire_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ce_i && sys_reg.cs_s2 && sys_reg.idle_cnt == IDLE_CYC |=> !sys_reg.resume)
        else $error("idle delay did not end continuation");
    wr_push_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ce_i && (sys_reg.wt_s2 != sys_reg.wt_d) && !sys_reg.push_v |=> sys_reg.push_v
        && sys_reg.push_w == {$past(lnk_reg.wr_addr), $past(lnk_reg.wr_data)})
        else $error("written word not queued");
    frame_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        sys_reg.cs_s2 |-> frm_reg.phase == SCS_PH_CMD && !miso_oe_o && frm_reg.bcnt == 4'h0)
        else $error("frame state not cleared by chip select");
    addr_step_a: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        lnk_reg.wr_tog != $past(lnk_reg.wr_tog) |-> lnk_reg.addr == $past(lnk_reg.addr) + 8'h01)
        else $error("address did not advance after word");
    msb_first_a: assert property (@(posedge sclk_i) disable iff (!frm_clr_b)
        lnk_reg.wr_tog != $past(lnk_reg.wr_tog) |-> lnk_reg.wr_data[0] == $past(mosi_i)
        && lnk_reg.wr_data[15] == $past(mosi_i, 16))
        else $error("data word not shifted msb first");
    miso_dir_a: assert property (@(negedge sclk_i) disable iff (!frm_clr_b)
        miso_oe_o |-> lnk_reg.cmd == SCS_CMD_RD && frm_reg.phase == SCS_PH_DATA)
        else $error("miso driven outside read data");

    wr_word_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        wr_valid_o && wr_ready_i);
    rd_fetch_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) rd_req_o);
    resume_c: cover property (@(posedge sclk_i) disable iff (!frm_clr_b)
        !frm_reg.started && sys_reg.resume && lnk_reg.cmd == SCS_CMD_WR);
    addr_wrap_c: cover property (@(posedge sclk_i) disable iff (!rst_b_i)
        (lnk_reg.wr_tog != $past(lnk_reg.wr_tog)) && lnk_reg.addr == 8'h00);
    nack_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        $past(i2c_hdr_valid_i) && !i2c_ack_o);

endmodule : scs_port

// ### scs_spi_master.sv
// SPI master model driving the configuration slave port in clock mode 0 or 3.
// Assumes one caller of frame() at a time.
`timescale 1ns/1ps

module scs_spi_master #(
    parameter real HALF = 80.0
) (
    // SPI link
    output logic      sclk_o,
    output logic      chip_select_n_o,
    output logic      mosi_o,
    input  wire logic miso_i,
    // Clock idle level: low selects mode 0, high selects mode 3.
    input  wire logic cpol_i
);
    initial begin
        sclk_o          = 1'b0;
        chip_select_n_o = 1'b1;
        mosi_o          = 1'b0;
    end

    // The clock stands at its idle level between frames; a released data line shows the
    // inverse of its last bit so stale data cannot pass for fresh data.
    task automatic frame(input logic [63:0] bits, input int n, output logic [63:0] rx);
        rx     = 64'h0;
        sclk_o = cpol_i;
        #1.3;
        chip_select_n_o = 1'b0;
        #(2.0 * HALF);
        for (int i = n - 1; i >= 0; i--) begin
            sclk_o = 1'b0;
            mosi_o = bits[i];
            #(HALF);
            sclk_o = 1'b1;
            rx     = {rx[62:0], miso_i};
            #(HALF);
        end
        sclk_o = cpol_i;
        #(2.0 * HALF);
        chip_select_n_o = 1'b1;
        mosi_o          = ~mosi_o;
    endtask : frame
endmodule : scs_spi_master

// ### serial_config_slave_port_tb.sv
// Bench of the configuration slave port: address selection, header match,
// stalled write stream, early frames, aborted and unknown frames, reads in
// clock modes 0 and 3, write overrun and clock enable freeze.
// Assumes the design files and scs_spi_master.sv are compiled first.
`timescale 1ns/1ps

module serial_config_slave_port_tb;
    import scs_pkg::*;

    logic        clk, rst_b, sclk, cs_n, mosi, miso, miso_oe, mode_f, sh, sl, ce, cpol;
    logic        hdr_v, ack, rd_q, wr_valid, wr_ready, wr_ovr, rd_req;
    scs_code_t   code;
    scs_slave_t  slave;
    logic [7:0]  hdr;
    scs_addr_t   wr_addr, rd_addr;
    scs_data_t   wr_data, rd_data;
    logic [23:0] q[$];
    logic [63:0] rx;
    int          miscompares, checks;

    scs_spi_master MST (.sclk_o(sclk), .chip_select_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
                        .cpol_i(cpol));

    scs_port #(.IDLE_CYC(15'h0064)) DUT (
        .clk_i(clk), .rst_b_i(rst_b), .ce_i(ce),
        .sclk_i(sclk), .chip_select_n_i(cs_n), .mosi_i(mosi),
        .miso_o(miso), .miso_oe_o(miso_oe),
        .addr_mode_factory_i(mode_f), .factory_code_i(code),
        .addr_strap_high_i(sh), .addr_strap_low_i(sl), .slave_addr_o(slave),
        .i2c_hdr_i(hdr), .i2c_hdr_valid_i(hdr_v), .i2c_ack_o(ack), .i2c_read_o(rd_q),
        .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .wr_ready_i(wr_ready), .wr_overrun_o(wr_ovr),
        .rd_req_o(rd_req), .rd_addr_o(rd_addr), .rd_data_i(rd_data)
    );

    // The register file answers a fetch, one cycle later, with its address and
    // the inverse of it; without a fetch pulse the read data never appears.
    always @(posedge clk) begin
        if (rd_req === 1'b1) begin
            rd_data <= {rd_addr, ~rd_addr};
        end
    end

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            q.push_back({wr_addr, wr_data});
        end
    end

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_flag

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic wait_words(input int n);
        for (int k = 0; k < 400 && q.size() < n; k++) @(negedge clk);
        if (q.size() < n) begin
            miscompares++;
            end_of_test();
        end
    endtask : wait_words

    task automatic idle();
        repeat (200) @(negedge clk);
    endtask : idle

    task automatic t_factory();
        mode_f = 1'b1;
        for (int c = 0; c < 16; c++) begin
            code = 4'(c);
            sh   = code[0];
            sl   = ~code[1];
            repeat (5) @(negedge clk);
            chk_val({17'h0, slave}, {17'h0, 3'b110, code});
        end
        ce   = 1'b0;
        code = 4'h0;
        repeat (5) @(negedge clk);
        chk_val({17'h0, slave}, {17'h0, 3'b110, 4'hF});
        ce   = 1'b1;
    endtask : t_factory

    task automatic t_pins();
        logic [6:0] pin_addr [4] = '{7'h60, 7'h62, 7'h68, 7'h6A};
        mode_f = 1'b0;
        for (int i = 0; i < 4; i++) begin
            sh = 1'(i >> 1);
            sl = 1'(i);
            repeat (5) @(negedge clk);
            chk_val({17'h0, slave}, {17'h0, pin_addr[i]});
        end
    endtask : t_pins

    task automatic t_header(input logic [7:0] h, input logic a);
        hdr   = h;
        hdr_v = 1'b1;
        @(negedge clk);
        hdr_v = 1'b0;
        repeat (2) @(negedge clk);
        chk_flag(ack, a);
        chk_flag(rd_q, h[0]);
    endtask : t_header

    task automatic t_write();
        wr_ready = 1'b0;
        MST.frame({8'h02, 8'hFE, 16'hA55A, 16'h1234, 16'h8001}, 64, rx);
        @(negedge clk);
        chk_flag(miso_oe, 1'b0);
        chk_val(24'(q.size()), 24'h0);
        wr_ready = 1'b1;
        wait_words(3);
        chk_val(q.pop_front(), 24'hFE_A55A);
        chk_val(q.pop_front(), 24'hFF_1234);
        chk_val(q.pop_front(), 24'h00_8001);
        MST.frame({48'h0, 16'h0203}, 16, rx);
        wait_words(1);
        chk_val(q.pop_front(), 24'h01_0203);
    endtask : t_write

    task automatic t_abort();
        idle();
        MST.frame(64'h15, 5, rx);
        idle();
        MST.frame({32'h0, 8'h55, 8'h00, 16'hFFFF}, 32, rx);
        idle();
        MST.frame({32'h0, 8'h02, 8'h40, 16'hBEEF}, 32, rx);
        wait_words(1);
        chk_val(q.pop_front(), 24'h40_BEEF);
    endtask : t_abort

    task automatic t_read();
        for (int m = 0; m < 2; m++) begin
            cpol = 1'(m);
            idle();
            MST.frame({16'h0, 8'h03, 8'h10, 32'h0}, 48, rx);
            chk_val({8'h0, rx[31:16]}, 24'h10EF);
            chk_val({8'h0, rx[15:0]}, 24'h11EE);
            @(negedge clk);
            chk_flag(miso_oe, 1'b0);
            chk_val(24'(q.size()), 24'h0);
        end
        cpol = 1'b0;
    endtask : t_read

    // Eleven words into a stalled sink: nine buffered, one pending, one dropped.
    task automatic t_overrun();
        chk_flag(wr_ovr, 1'b0);
        idle();
        wr_ready = 1'b0;
        MST.frame({8'h02, 8'h80, 48'h0}, 64, rx);
        for (int f = 0; f < 2; f++) begin
            repeat (4) @(negedge clk);
            MST.frame(64'h0, 64, rx);
        end
        @(negedge clk);
        chk_flag(wr_ovr, 1'b1);
        wr_ready = 1'b1;
        wait_words(10);
        repeat (20) @(negedge clk);
        chk_val(24'(q.size()), 24'h00_000A);
        chk_val(q[9], 24'h89_0000);
    endtask : t_overrun

    initial begin
        {clk, rst_b, mode_f, sh, sl, hdr_v, wr_ready, cpol} = '0;
        ce          = 1'b1;
        code        = 4'h0;
        hdr         = 8'h00;
        miscompares = 0;
        checks      = 0;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        t_factory();
        t_pins();
        t_header({7'h6A, 1'b1}, 1'b1);
        t_header({7'h6B, 1'b0}, 1'b0);
        t_write();
        t_abort();
        t_read();
        t_overrun();
        end_of_test();
    end
endmodule : serial_config_slave_port_tb
